/* cfb_ctrl.sv */
// can flag acknowledge, init/sleep handshake and bus-off recovery with axi4-lite registers
module cfb_ctrl
    import cfb_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    // axi4-lite write channels
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // axi4-lite read channels
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // frame engine side
    input  wire cfb_flag_evt_type flag_evt,
    input  wire logic             busoff_enter,
    input  wire logic             bus_idle,
    input  wire logic             bit_tick,
    input  wire logic             engine_tx_bit,
    // can bus pins
    input  wire logic             bus_receive_pin,
    output logic                  bus_transmit_pin,
    // status and interrupt
    output logic                  busoff_state,
    output logic                  irq
);
    cfb_state_type s_reg;
    cfb_state_type s_next;

    // address match shared by read and write decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        return addr[7:2] == off[7:2];
    endfunction

    logic       aw_fire;
    logic       w_fire;
    logic       wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic       wr_lane0;
    logic       sleep_active;
    logic       recessive_run;
    logic       hold_clr;

    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire  = s_axi_wvalid && s_axi_wready;
    assign wr_go   = (s_reg.aw_held || aw_fire) && (s_reg.w_held || w_fire) && !s_reg.bvalid;
    assign wr_addr = s_reg.aw_held ? s_reg.awaddr : s_axi_awaddr;
    assign wr_data = s_reg.w_held ? s_reg.wdata : s_axi_wdata;
    assign wr_lane0 = s_reg.w_held ? s_reg.wstrb[0] : s_axi_wstrb[0];
    assign sleep_active = s_reg.sleep_request && s_reg.sleep_acknowledge;
    assign hold_clr = wr_go && wr_lane0 && hit(wr_addr, MISC_OFF) && wr_data[MISC_HOLD_BIT];
    // a run completes on the eleventh recessive sample
    assign recessive_run = bit_tick && s_reg.rx_level && (s_reg.bit_cnt == REC_BITS - 4'd1);

    // next-state logic for bus, flags, modes and recovery
    always_comb begin
        logic       mapped;
        logic       completing;
        logic [31:0] rd;
        mapped     = 1'b0;
        completing = 1'b0;
        rd         = 32'h0000_0000;
        s_next     = s_reg;

        // rx pin: three stages, level moves once stages two and three agree
        s_next.rx_sync = {s_reg.rx_sync[1:0], bus_receive_pin};
        if (s_reg.rx_sync[1] == s_reg.rx_sync[2]) begin
            s_next.rx_level = s_reg.rx_sync[2];
        end

        // write channel capture, either order
        if (aw_fire) begin
            s_next.aw_held = 1'b1;
            s_next.awaddr  = s_axi_awaddr;
        end
        if (w_fire) begin
            s_next.w_held = 1'b1;
            s_next.wdata  = s_axi_wdata;
            s_next.wstrb  = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // hardware flag sets win over a same-cycle clear
        s_next.rflag = s_reg.rflag | flag_evt.rx_set;
        s_next.tflag = s_reg.tflag | flag_evt.tx_set;

        if (wr_go) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            mapped = hit(wr_addr, CTRL_OFF) || hit(wr_addr, MISC_OFF) || hit(wr_addr, RFLG_OFF)
                || hit(wr_addr, RMSK_OFF) || hit(wr_addr, TFLG_OFF) || hit(wr_addr, TMSK_OFF)
                || hit(wr_addr, STAT_OFF);
            s_next.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane0) begin
                if (hit(wr_addr, CTRL_OFF)) begin
                    s_next.enable       = wr_data[CTRL_EN_BIT];
                    s_next.init_request = wr_data[CTRL_INIT_BIT];
                    // sleep request cannot be withdrawn before sleep is active
                    if (wr_data[CTRL_SLP_BIT] || sleep_active) begin
                        s_next.sleep_request = wr_data[CTRL_SLP_BIT];
                    end
                    // recovery mode only changes in initialization mode
                    if (s_reg.init_acknowledge) begin
                        s_next.busoff_recovery_mode = wr_data[CTRL_MODE_BIT];
                    end
                end
                // write one clears unless the setting condition persists
                if (hit(wr_addr, RFLG_OFF)) begin
                    s_next.rflag = (s_reg.rflag & ~(wr_data[7:0] & ~flag_evt.rx_cond))
                        | flag_evt.rx_set;
                end
                if (hit(wr_addr, TFLG_OFF)) begin
                    s_next.tflag = (s_reg.tflag & ~(wr_data[2:0] & ~flag_evt.tx_cond))
                        | flag_evt.tx_set;
                end
                if (hit(wr_addr, RMSK_OFF)) begin
                    s_next.rmask = wr_data[7:0];
                end
                if (hit(wr_addr, TMSK_OFF)) begin
                    s_next.tmask = wr_data[2:0];
                end
            end
        end

        // read channel: one outstanding, decoded at acceptance
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            if (hit(s_axi_araddr, CTRL_OFF)) begin
                rd[CTRL_EN_BIT]   = s_reg.enable;
                rd[CTRL_INIT_BIT] = s_reg.init_request;
                rd[CTRL_SLP_BIT]  = s_reg.sleep_request;
                rd[CTRL_MODE_BIT] = s_reg.busoff_recovery_mode;
                rd[CTRL_IACK_BIT] = s_reg.init_acknowledge;
                rd[CTRL_SACK_BIT] = s_reg.sleep_acknowledge;
            end else if (hit(s_axi_araddr, MISC_OFF)) begin
                rd[MISC_HOLD_BIT] = s_reg.busoff_hold;
            end else if (hit(s_axi_araddr, RFLG_OFF)) begin
                rd[7:0] = s_reg.rflag;
            end else if (hit(s_axi_araddr, RMSK_OFF)) begin
                rd[7:0] = s_reg.rmask;
            end else if (hit(s_axi_araddr, TFLG_OFF)) begin
                rd[2:0] = s_reg.tflag;
            end else if (hit(s_axi_araddr, TMSK_OFF)) begin
                rd[2:0] = s_reg.tmask;
            end else if (hit(s_axi_araddr, STAT_OFF)) begin
                rd = {14'h0000, s_reg.seq_done, s_reg.busoff, s_reg.occ_cnt, 4'h0, s_reg.bit_cnt};
            end else begin
                s_next.rresp = RESP_SLVERR;
            end
            s_next.rdata = rd;
        end

        // handshakes: sleep ack once the bus is idle, init ack once idle or asleep
        s_next.sleep_acknowledge = s_reg.enable && s_reg.sleep_request
            && (s_reg.sleep_acknowledge || bus_idle);
        s_next.init_acknowledge = s_reg.enable && s_reg.init_request
            && (s_reg.init_acknowledge || bus_idle || sleep_active);

        // recessive-run counting only while bus-off and awake
        if (s_reg.busoff && !sleep_active && !s_reg.seq_done) begin
            if (bit_tick) begin
                if (!s_reg.rx_level) begin
                    s_next.bit_cnt = 4'd0;
                end else if (recessive_run) begin
                    s_next.bit_cnt = 4'd0;
                    s_next.occ_cnt = s_reg.occ_cnt + 8'd1;
                    completing = (s_reg.occ_cnt == REC_OCC - 8'd1);
                end else begin
                    s_next.bit_cnt = s_reg.bit_cnt + 4'd1;
                end
            end
        end
        s_next.seq_done = s_reg.seq_done || completing;
        if (hold_clr) begin
            s_next.busoff_hold = 1'b0;
        end

        // leave bus-off: automatic on the count, user mode also needs hold cleared
        if (s_reg.busoff && s_next.seq_done
            && (!s_reg.busoff_recovery_mode || !s_next.busoff_hold)) begin
            s_next.busoff   = 1'b0;
            s_next.seq_done = 1'b0;
            s_next.occ_cnt  = 8'd0;
            s_next.bit_cnt  = 4'd0;
        end
        // entering bus-off restarts counting and arms the hold in user mode
        if (busoff_enter && s_reg.enable) begin
            s_next.busoff      = 1'b1;
            s_next.seq_done    = 1'b0;
            s_next.occ_cnt     = 8'd0;
            s_next.bit_cnt     = 4'd0;
            s_next.busoff_hold = s_reg.busoff_recovery_mode;
        end

        // pin and interrupt taken from next state so they track it exactly
        s_next.tx_pin = (!s_next.enable || s_next.init_acknowledge || s_next.busoff
            || (s_next.sleep_request && s_next.sleep_acknowledge)) ? 1'b1 : engine_tx_bit;
        s_next.irq = |(s_next.rflag & s_next.rmask) || |(s_next.tflag & s_next.tmask);
    end

    // single state register, everything resets to a constant
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg                      <= '0;
            s_reg.enable               <= EN_RST;
            s_reg.init_request         <= INIT_RST;
            s_reg.busoff_recovery_mode <= MODE_RST;
            s_reg.rmask                <= RMSK_RST;
            s_reg.tmask                <= TMSK_RST;
            s_reg.tflag                <= TFLG_RST;
            s_reg.rx_sync              <= 3'b111;
            s_reg.rx_level             <= 1'b1;
            s_reg.tx_pin               <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ports
    assign s_axi_awready    = !s_reg.aw_held && !s_reg.bvalid;
    assign s_axi_wready     = !s_reg.w_held && !s_reg.bvalid;
    assign s_axi_bvalid     = s_reg.bvalid;
    assign s_axi_bresp      = s_reg.bresp;
    assign s_axi_arready    = !s_reg.rvalid;
    assign s_axi_rvalid     = s_reg.rvalid;
    assign s_axi_rdata      = s_reg.rdata;
    assign s_axi_rresp      = s_reg.rresp;
    assign bus_transmit_pin = s_reg.tx_pin;
    assign busoff_state     = s_reg.busoff;
    assign irq              = s_reg.irq;

    // write of a one to receive flag 0 with no set and no condition
    sequence s_rflag0_clear;
        wr_go && wr_lane0 && hit(wr_addr, RFLG_OFF) && wr_data[0]
            && !flag_evt.rx_cond[0] && !flag_evt.rx_set[0];
    endsequence
    sequence s_rflag0_keep;
        wr_go && hit(wr_addr, RFLG_OFF) && !wr_data[0] && s_reg.rflag[0];
    endsequence
    sequence s_last_run;
        s_reg.busoff && !sleep_active && !s_reg.seq_done && recessive_run
            && s_reg.occ_cnt == 8'd127 && !busoff_enter;
    endsequence

    property p_irq_level;
        @(posedge core_clk) disable iff (sys_rst)
        (|(s_reg.rflag & s_reg.rmask) || |(s_reg.tflag & s_reg.tmask)) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq low with pending flag");

    property p_w1c_clear;
        @(posedge core_clk) disable iff (sys_rst)
        s_rflag0_clear |=> !s_reg.rflag[0];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("flag not cleared by one");

    property p_w0_keep;
        @(posedge core_clk) disable iff (sys_rst)
        s_rflag0_keep |=> s_reg.rflag[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

    property p_cond_blocks;
        @(posedge core_clk) disable iff (sys_rst)
        (s_reg.rflag[0] && flag_evt.rx_cond[0]) |=> s_reg.rflag[0];
    endproperty
    a_cond_blocks: assert property (p_cond_blocks) else $error("flag cleared under cond");

    property p_reset_auto;
        @(posedge core_clk) disable iff (sys_rst)
        $past(sys_rst) |-> !s_reg.busoff_recovery_mode && !s_reg.busoff;
    endproperty
    a_reset_auto: assert property (p_reset_auto) else $error("not automatic after reset");

    property p_auto_recover;
        @(posedge core_clk) disable iff (sys_rst)
        (s_last_run and ##0 !s_reg.busoff_recovery_mode) |=> !s_reg.busoff;
    endproperty
    a_auto_recover: assert property (p_auto_recover) else $error("no auto recovery");

    property p_user_hold;
        @(posedge core_clk) disable iff (sys_rst)
        (s_reg.busoff && s_reg.busoff_recovery_mode && s_reg.busoff_hold && !hold_clr)
            |=> s_reg.busoff;
    endproperty
    a_user_hold: assert property (p_user_hold) else $error("left bus-off while held");

    property p_user_both;
        @(posedge core_clk) disable iff (sys_rst)
        (s_reg.busoff && s_reg.seq_done && !s_reg.busoff_hold && !busoff_enter)
            |=> !s_reg.busoff && s_reg.occ_cnt == 8'd0;
    endproperty
    a_user_both: assert property (p_user_both) else $error("no recovery with both");

    property p_sleep_ack;
        @(posedge core_clk) disable iff (sys_rst)
        s_reg.sleep_acknowledge |-> $past(s_reg.sleep_request) && $past(s_reg.enable);
    endproperty
    a_sleep_ack: assert property (p_sleep_ack) else $error("sleep ack without request");

    property p_sleep_freeze;
        @(posedge core_clk) disable iff (sys_rst)
        (sleep_active && s_reg.busoff && !busoff_enter)
            |-> bus_transmit_pin ##1 $stable(s_reg.occ_cnt);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("activity in sleep");
endmodule

/* cfb_pkg.sv */
// constants, carrier types and state layout for the can flag, init and bus-off block
//
// Behaviour
// - interrupt output stays high while any unmasked receive or transmit flag is set
// - writing one to a flag bit clears it; writing zero leaves it alone
// - a clear is ignored while the condition that sets the flag persists
// - after reset the bus-off recovery mode is automatic
// - automatic mode leaves bus-off after 128 runs of 11 recessive bits
// - user mode also needs software to clear the bus-off hold bit
// - user mode: count condition and hold clear may come in either order
// - sleep is active only with both sleep request and sleep acknowledge set
// - in sleep: recessive counting frozen, transmit pin recessive, resumes after wake
package cfb_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF  = 8'h00;
    localparam logic [7:0] MISC_OFF  = 8'h04;
    localparam logic [7:0] RFLG_OFF  = 8'h08;
    localparam logic [7:0] RMSK_OFF  = 8'h0C;
    localparam logic [7:0] TFLG_OFF  = 8'h10;
    localparam logic [7:0] TMSK_OFF  = 8'h14;
    localparam logic [7:0] STAT_OFF  = 8'h18;
    // control and misc register field positions
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_INIT_BIT = 1;
    localparam int CTRL_SLP_BIT  = 2;
    localparam int CTRL_MODE_BIT = 3;
    localparam int CTRL_IACK_BIT = 4;
    localparam int CTRL_SACK_BIT = 5;
    localparam int MISC_HOLD_BIT = 0;
    // reset values
    localparam logic       EN_RST    = 1'b0;
    localparam logic       INIT_RST  = 1'b1;
    localparam logic       MODE_RST  = 1'b0;
    localparam logic [7:0] RMSK_RST  = 8'h00;
    localparam logic [2:0] TMSK_RST  = 3'h0;
    localparam logic [2:0] TFLG_RST  = 3'h7;
    // bus-off recovery counts
    localparam logic [3:0] REC_BITS  = 4'd11;
    localparam logic [7:0] REC_OCC   = 8'd128;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // flag events from the frame engine, same clock
    typedef struct packed {
        logic [7:0] rx_set;
        logic [7:0] rx_cond;
        logic [2:0] tx_set;
        logic [2:0] tx_cond;
    } cfb_flag_evt_type;

    // complete state of the block
    typedef struct packed {
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        enable;
        logic        init_request;
        logic        init_acknowledge;
        logic        sleep_request;
        logic        sleep_acknowledge;
        logic        busoff_recovery_mode;
        logic        busoff_hold;
        logic        busoff;
        logic        seq_done;
        logic [3:0]  bit_cnt;
        logic [7:0]  occ_cnt;
        logic [7:0]  rflag;
        logic [7:0]  rmask;
        logic [2:0]  tflag;
        logic [2:0]  tmask;
        logic [2:0]  rx_sync;
        logic        rx_level;
        logic        tx_pin;
        logic        irq;
    } cfb_state_type;
endpackage

/* cfb_bus_model.sv */
// can bus model: receive level, idle flag and bit sample ticks
module cfb_bus_model #(
    parameter int TICK_DIV = 2
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // another node holding the line dominant
    input  wire logic line_dominant,
    // bus side seen by the block
    output logic      bit_tick,
    output logic      bus_receive_pin,
    output logic      bus_idle
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] div_reg;

    // line rests recessive and idle unless another node drives it dominant
    assign bus_receive_pin = !line_dominant;
    assign bus_idle        = !line_dominant;

    // one sample point every TICK_DIV clocks keeps recovery runs short
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg  <= 8'h00;
            bit_tick <= 1'b0;
        end else begin
            div_reg  <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
            bit_tick <= (div_reg == 8'(TICK_DIV - 1));
        end
    end
endmodule

/* test_cfb_ctrl.sv */
// register-level testbench of the can flag, init and bus-off block
module test_cfb_ctrl;
    import cfb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic             core_clk, sys_rst;
    logic [7:0]       s_axi_awaddr, s_axi_araddr;
    logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]       s_axi_wstrb;
    logic [1:0]       s_axi_bresp, s_axi_rresp, rs;
    logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic             s_axi_rvalid, s_axi_rready;
    cfb_flag_evt_type flag_evt;
    logic             busoff_enter, bus_idle, bit_tick, engine_tx_bit;
    logic             bus_receive_pin, bus_transmit_pin, busoff_state, irq;
    logic             line_dominant;
    int               failures, checked, n;

    cfb_ctrl i_cfb_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .flag_evt(flag_evt), .busoff_enter(busoff_enter),
        .bus_idle(bus_idle), .bit_tick(bit_tick), .engine_tx_bit(engine_tx_bit),
        .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
        .busoff_state(busoff_state), .irq(irq));

    cfb_bus_model i_cfb_bus_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .line_dominant(line_dominant),
        .bit_tick(bit_tick), .bus_receive_pin(bus_receive_pin), .bus_idle(bus_idle));

    // 250 MHz
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] act, input logic [31:0] exp);
        checked++;
        if (act !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic give_up();
        failures++;
        $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    // ready is judged at the falling edge, so release lands right after the taking edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        int   k;
        k = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (k < 50) begin
            @(negedge core_clk);
            k++;
            aw_hit = s_axi_awvalid & s_axi_awready;
            w_hit  = s_axi_wvalid & s_axi_wready;
            b_hit  = s_axi_bvalid;
            rs     = s_axi_bresp;
            @(posedge core_clk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (!b_hit) give_up();
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic ar_hit, r_hit;
        int   k;
        k = 0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (k < 50) begin
            @(negedge core_clk);
            k++;
            ar_hit = s_axi_arvalid & s_axi_arready;
            r_hit  = s_axi_rvalid;
            rd     = s_axi_rdata;
            rs     = s_axi_rresp;
            @(posedge core_clk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (!r_hit) give_up();
    endtask

    task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check_word(rd, exp);
    endtask

    // polls a control bit until it reaches the wanted level
    task automatic poll_ctrl(input int b, input logic v);
        int k;
        for (k = 0; k < 20; k++) begin
            axi_read(CTRL_OFF);
            if (rd[b] === v) break;
        end
        check_word({31'h0, rd[b]}, {31'h0, v});
        if (rd[b] !== v) give_up();
    endtask

    task automatic enter_busoff();
        @(posedge core_clk);
        busoff_enter <= 1'b1;
        @(posedge core_clk);
        busoff_enter <= 1'b0;
    endtask

    // counts cycles until bus-off ends, bounded by lim
    task automatic wait_recover(input int lim);
        n = 0;
        while (busoff_state !== 1'b0 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (busoff_state !== 1'b0) give_up();
    endtask

    initial begin
        failures = 0;
        checked = 0;
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        flag_evt = '0;
        busoff_enter = 1'b0;
        engine_tx_bit = 1'b0;
        line_dominant = 1'b0;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values and an unmapped place
        read_check(CTRL_OFF, 32'h0000_0002);
        read_check(TFLG_OFF, 32'h0000_0007);
        read_check(RFLG_OFF, 32'h0000_0000);
        read_check(8'h1C, 32'h0000_0000);
        check_word({30'h0, rs}, {30'h0, RESP_SLVERR});
        $display("test reset values done");
        // startup: enable, configure in init, leave init
        axi_write(CTRL_OFF, 32'h0000_0003);
        poll_ctrl(CTRL_IACK_BIT, 1'b1);
        axi_write(RMSK_OFF, 32'h0000_00FF);
        axi_write(CTRL_OFF, 32'h0000_0001);
        poll_ctrl(CTRL_IACK_BIT, 1'b0);
        check_word({31'h0, bus_transmit_pin}, 32'h0000_0000);
        // unmapped write answers with an error, a write with lane 0 off changes nothing
        axi_write(8'h1C, 32'h0000_0001);
        check_word({30'h0, rs}, {30'h0, RESP_SLVERR});
        s_axi_wstrb <= 4'h0;
        axi_write(RMSK_OFF, 32'h0000_0000);
        check_word({30'h0, rs}, {30'h0, RESP_OKAY});
        s_axi_wstrb <= 4'hF;
        read_check(RMSK_OFF, 32'h0000_00FF);
        $display("test startup done");
        // flags: zero write, blocked clear, single-bit clear
        @(posedge core_clk);
        flag_evt.rx_set <= 8'h05;
        @(posedge core_clk);
        flag_evt.rx_set <= 8'h00;
        flag_evt.rx_cond <= 8'h01;
        axi_write(RFLG_OFF, 32'h0000_0000);
        read_check(RFLG_OFF, 32'h0000_0005);
        axi_write(RFLG_OFF, 32'h0000_0001);
        read_check(RFLG_OFF, 32'h0000_0005);
        check_word({31'h0, irq}, 32'h0000_0001);
        flag_evt.rx_cond <= 8'h00;
        axi_write(RFLG_OFF, 32'h0000_0001);
        read_check(RFLG_OFF, 32'h0000_0004);
        check_word({31'h0, irq}, 32'h0000_0001);
        axi_write(RFLG_OFF, 32'h0000_0004);
        check_word({31'h0, irq}, 32'h0000_0000);
        axi_write(TMSK_OFF, 32'h0000_0002);
        check_word({31'h0, irq}, 32'h0000_0001);
        axi_write(TFLG_OFF, 32'h0000_0002);
        read_check(TFLG_OFF, 32'h0000_0005);
        check_word({31'h0, irq}, 32'h0000_0000);
        $display("test flags done");
        // automatic recovery: 128 runs of 11 ticks, one tick every two clocks
        enter_busoff();
        @(negedge core_clk);
        check_word({31'h0, bus_transmit_pin}, 32'h0000_0001);
        wait_recover(4000);
        check_word({31'h0, (n >= 2810 && n <= 2825)}, 32'h0000_0001);
        $display("test auto recovery done");
        // reconfigure through sleep and init to user recovery; busy line delays the ack
        @(posedge core_clk);
        line_dominant <= 1'b1;
        axi_write(CTRL_OFF, 32'h0000_0005);
        read_check(CTRL_OFF, 32'h0000_0005);
        line_dominant <= 1'b0;
        poll_ctrl(CTRL_SACK_BIT, 1'b1);
        axi_write(CTRL_OFF, 32'h0000_0007);
        poll_ctrl(CTRL_IACK_BIT, 1'b1);
        axi_write(CTRL_OFF, 32'h0000_000F);
        axi_write(CTRL_OFF, 32'h0000_000D);
        poll_ctrl(CTRL_IACK_BIT, 1'b0);
        axi_write(CTRL_OFF, 32'h0000_0009);
        poll_ctrl(CTRL_SACK_BIT, 1'b0);
        read_check(CTRL_OFF, 32'h0000_0009);
        $display("test reconfigure done");
        // user mode, count completes before the hold is cleared
        enter_busoff();
        repeat (3000) @(posedge core_clk);
        check_word({31'h0, busoff_state}, 32'h0000_0001);
        read_check(MISC_OFF, 32'h0000_0001);
        read_check(STAT_OFF, 32'h0003_8000);
        axi_write(MISC_OFF, 32'h0000_0001);
        wait_recover(5);
        check_word({31'h0, busoff_state}, 32'h0000_0000);
        $display("test user recovery done");
        // hold cleared first, then sleep freezes the count
        enter_busoff();
        axi_write(MISC_OFF, 32'h0000_0001);
        axi_write(CTRL_OFF, 32'h0000_000D);
        poll_ctrl(CTRL_SACK_BIT, 1'b1);
        repeat (3000) @(posedge core_clk);
        check_word({30'h0, busoff_state, bus_transmit_pin}, 32'h0000_0003);
        axi_write(CTRL_OFF, 32'h0000_0009);
        wait_recover(4000);
        check_word({31'h0, (n >= 2000 && n < 4000)}, 32'h0000_0001);
        $display("test sleep freeze done");
        report_and_stop();
    end
endmodule
